// ### hw/sarseq_top.sv
`timescale 1ns/1ps
`default_nettype none
module sarseq_top (
    input  wire logic                        i_clock,
    input  wire logic                        i_rst_b,
    input  wire logic [sarseq_pkg::ADDR_W-1:0] i_addr,
    input  wire logic [sarseq_pkg::DATA_W-1:0] i_wdata,
    input  wire logic                        i_wr,
    input  wire logic                        i_rd,
    output logic      [sarseq_pkg::DATA_W-1:0] o_rdata,
    input  wire logic                        i_ext_trigger,
    input  wire logic                        i_pwm_center,
    input  wire logic [3:0]                  i_clk_src,
    output logic                             o_conv_tick,
    output logic                             o_core_start,
    output logic      [sarseq_pkg::CH_W-1:0] o_core_channel,
    output logic                             o_core_diff,
    output logic      [1:0]                  o_ch7_src,
    input  wire logic                        i_core_done,
    input  wire logic [sarseq_pkg::RES_W-1:0] i_core_result,
    output logic                             o_irq
);
    import sarseq_pkg::*;

    // software control state
    logic               irq_en_q;      // interrupt enable
    sarseq_mode_e       mode_q;        // operating mode
    logic [1:0]         trigger_source_select_q;        // trigger source select
    logic [1:0]         tcond_q;       // trigger condition
    logic               ext_trigger_enable_q;       // external trigger enable
    logic               diff_q;        // differential pairing
    logic               start_q;       // conversion start / busy
    logic [1:0]         ch7_q;         // channel seven source
    logic [NCH-1:0]     channel_enable_bits_q;        // channel enable bits
    logic [7:0]         div_q;         // divide value
    logic [1:0]         sel_q;         // clock source select
    logic               done_q;        // conversion done flag
    // sequencer
    sarseq_state_e      state_q;
    logic [NCH-1:0]     pend_q;        // channels still to convert
    logic [CH_W-1:0]    cur_q;         // channel under conversion
    // results
    logic [RES_W-1:0]   res_q [NCH];
    logic [NCH-1:0]     valid_q;
    logic [NCH-1:0]     ovr_q;
    // trigger filter
    logic               pin_prev_q;    // pin a cycle ago
    logic [RUN_W-1:0]   run_q;         // cycles pin has held
    logic               filt_q;        // last accepted pin state
    logic               trig_fire;     // start request from trigger
    // divider
    logic               src_prev_q;
    logic [7:0]         div_cnt_q;

    // decoded strobes
    logic wr_ctrl;
    logic wr_channel_enable_bits;
    logic wr_stat;
    logic wr_clk;
    logic rd_res;
    logic [CH_W-1:0] rd_ch;
    logic [NCH-1:0]  channel_enable_bits_eff;
    logic [NCH-1:0]  seq_mask;
    logic            pass_end;
    logic            store;

    assign wr_ctrl = i_wr && (i_addr == OFS_CTRL);
    assign wr_channel_enable_bits = i_wr && (i_addr == OFS_CHANNEL_ENABLE_BITS);
    assign wr_stat = i_wr && (i_addr == OFS_STAT);
    assign wr_clk  = i_wr && (i_addr == OFS_CLK);
    // result regs occupy the eight words below the control word
    assign rd_res  = i_rd && (i_addr < OFS_CTRL) && (i_addr[1:0] == 2'h0);
    assign rd_ch   = i_addr[4:2];
    assign store   = (state_q == ST_WAIT) && i_core_done;

    // lowest set bit of a channel mask
    function automatic logic [CH_W-1:0] lowest(input logic [NCH-1:0] m);
        logic [CH_W-1:0] r;
        r = '0;
        for (int i = NCH - 1; i >= 0; i--) begin
            if (m[i]) begin
                r = CH_W'(i);
            end
        end
        return r;
    endfunction : lowest

    // pairs use only the even input of each pair
    always_comb begin
        channel_enable_bits_eff = diff_q ? (channel_enable_bits_q & 8'h55) : channel_enable_bits_q;
        // single mode keeps only the lowest enabled channel
        seq_mask = '0;
        if ((mode_q == MODE_SINGLE) || (mode_q == MODE_RSVD)) begin
            if (channel_enable_bits_eff != '0) begin
                seq_mask[lowest(channel_enable_bits_eff)] = 1'b1;
            end
        end else begin
            seq_mask = channel_enable_bits_eff;
        end
    end

    // pin filter: run length of the current pin level, saturating
    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            pin_prev_q <= 1'b0;
            run_q      <= '0;
            filt_q     <= 1'b0;
        end else begin
            pin_prev_q <= i_ext_trigger;
            if (i_ext_trigger != pin_prev_q) begin
                run_q <= 4'h1;
            end else if (run_q != LEVEL_HOLD_CYC) begin
                run_q <= run_q + 4'h1;
            end
            // a new state counts only once held long enough
            if ((run_q >= EDGE_HOLD_CYC) && (pin_prev_q != filt_q)) begin
                filt_q <= pin_prev_q;
            end
        end
    end

    // trigger decode; level mode retriggers while the level holds
    always_comb begin
        trig_fire = 1'b0;
        if (ext_trigger_enable_q && !start_q) begin
            if (trigger_source_select_q == TRG_PWM) begin
                trig_fire = i_pwm_center;
            end else if (trigger_source_select_q == TRG_PIN) begin
                case (tcond_q)
                    COND_LOW:  trig_fire = !pin_prev_q && (run_q == LEVEL_HOLD_CYC);
                    COND_HIGH: trig_fire = pin_prev_q && (run_q == LEVEL_HOLD_CYC);
                    COND_FALL: trig_fire = (run_q >= EDGE_HOLD_CYC) && filt_q && !pin_prev_q;
                    COND_RISE: trig_fire = (run_q >= EDGE_HOLD_CYC) && !filt_q && pin_prev_q;
                    default:   trig_fire = 1'b0;
                endcase
            end
        end
    end

    // control register; software writes take effect at once, even mid-sequence
    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            irq_en_q <= 1'b0;
            mode_q   <= MODE_SINGLE;
            trigger_source_select_q   <= TRG_PIN;
            tcond_q  <= COND_LOW;
            ext_trigger_enable_q  <= 1'b0;
            diff_q   <= 1'b0;
            ch7_q    <= 2'h0;
        end else if (wr_ctrl) begin
            irq_en_q <= i_wdata[CTRL_IE_BIT];
            mode_q   <= sarseq_mode_e'(i_wdata[CTRL_MODE_LSB +: 2]);
            trigger_source_select_q   <= i_wdata[CTRL_TRIGGER_SOURCE_SELECT_LSB +: 2];
            tcond_q  <= i_wdata[CTRL_TCOND_LSB +: 2];
            ext_trigger_enable_q  <= i_wdata[CTRL_EXT_TRIGGER_ENABLE_BIT];
            diff_q   <= i_wdata[CTRL_DIFF_BIT];
            ch7_q    <= i_wdata[CTRL_CH7_LSB +: 2];
        end
    end

    // start bit: trigger set beats software, end-of-run clear beats all
    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            start_q <= 1'b0;
        end else if (state_q == ST_NEXT && pass_end &&
                     (mode_q != MODE_CONT || channel_enable_bits_eff == '0)) begin
            start_q <= 1'b0;
        end else if (state_q == ST_IDLE && start_q && seq_mask == '0) begin
            start_q <= 1'b0;                // nothing enabled, give up
        end else if (trig_fire) begin
            start_q <= 1'b1;
        end else if (wr_ctrl) begin
            start_q <= i_wdata[CTRL_START_BIT];
        end
    end

    // other configuration registers
    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            channel_enable_bits_q <= CHANNEL_ENABLE_BITS_RST;
            div_q  <= DIV_RST;
            sel_q  <= SEL_RST;
        end else begin
            if (wr_channel_enable_bits) begin
                channel_enable_bits_q <= i_wdata[NCH-1:0];
            end
            if (wr_clk) begin
                div_q <= i_wdata[CLK_DIV_LSB +: 8];
                sel_q <= i_wdata[CLK_SEL_LSB +: 2];
            end
        end
    end

    assign pass_end = (pend_q == '0);

    // sequencer: one conversion at a time, core done gates progress
    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            state_q <= ST_IDLE;
            pend_q  <= '0;
            cur_q   <= '0;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    if (start_q && seq_mask != '0) begin
                        pend_q  <= seq_mask;
                        cur_q   <= lowest(seq_mask);
                        state_q <= ST_START;
                    end
                end
                ST_START: begin
                    state_q <= ST_WAIT;
                end
                ST_WAIT: begin
                    if (i_core_done) begin
                        pend_q[cur_q] <= 1'b0;
                        state_q       <= ST_NEXT;
                    end
                end
                ST_NEXT: begin
                    if (!start_q) begin
                        state_q <= ST_IDLE;
                    end else if (!pass_end) begin
                        cur_q   <= lowest(pend_q);
                        state_q <= ST_START;
                    end else if (mode_q == MODE_CONT && channel_enable_bits_eff != '0) begin
                        pend_q  <= channel_enable_bits_eff;
                        cur_q   <= lowest(channel_enable_bits_eff);
                        state_q <= ST_START;
                    end else begin
                        state_q <= ST_IDLE;
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    // done flag: a pass end wins over a write-one clear
    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            done_q <= 1'b0;
        end else if (state_q == ST_NEXT && start_q && pass_end) begin
            done_q <= 1'b1;
        end else if (wr_stat && i_wdata[STAT_DONE_BIT]) begin
            done_q <= 1'b0;
        end
    end

    // results: a read takes the word; a new store wins over the take
    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            valid_q <= '0;
            ovr_q   <= '0;
            for (int i = 0; i < NCH; i++) begin
                res_q[i] <= '0;
            end
        end else begin
            if (rd_res) begin
                valid_q[rd_ch] <= 1'b0;
                ovr_q[rd_ch]   <= 1'b0;
            end
            if (store) begin
                res_q[cur_q]   <= i_core_result;
                valid_q[cur_q] <= 1'b1;
                // unread earlier word is lost, flag it
                if (valid_q[cur_q] && !(rd_res && rd_ch == cur_q)) begin
                    ovr_q[cur_q] <= 1'b1;
                end else begin
                    ovr_q[cur_q] <= 1'b0;
                end
            end
        end
    end

    // divider on the selected source; sources are sampled levels
    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            src_prev_q  <= 1'b0;
            div_cnt_q   <= '0;
            o_conv_tick <= 1'b0;
        end else begin
            src_prev_q  <= i_clk_src[sel_q];
            o_conv_tick <= 1'b0;
            if (i_clk_src[sel_q] && !src_prev_q) begin
                if (div_cnt_q >= div_q) begin
                    div_cnt_q   <= '0;
                    o_conv_tick <= 1'b1;
                end else begin
                    div_cnt_q <= div_cnt_q + 8'h01;
                end
            end
        end
    end

    // read port: data stand one cycle after the strobe, unmapped reads zero
    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_rdata <= '0;
        end else begin
            o_rdata <= '0;
            if (rd_res) begin
                o_rdata[RES_W-1:0]    <= res_q[rd_ch];
                o_rdata[RES_OVR_BIT]  <= ovr_q[rd_ch];
                o_rdata[RES_VALID_BIT] <= valid_q[rd_ch];
            end else if (i_rd) begin
                case (i_addr)
                    OFS_CTRL: begin
                        o_rdata[CTRL_IE_BIT]        <= irq_en_q;
                        o_rdata[CTRL_MODE_LSB +: 2] <= mode_q;
                        o_rdata[CTRL_TRIGGER_SOURCE_SELECT_LSB +: 2] <= trigger_source_select_q;
                        o_rdata[CTRL_TCOND_LSB +: 2] <= tcond_q;
                        o_rdata[CTRL_EXT_TRIGGER_ENABLE_BIT]     <= ext_trigger_enable_q;
                        o_rdata[CTRL_DIFF_BIT]      <= diff_q;
                        o_rdata[CTRL_START_BIT]     <= start_q;
                        o_rdata[CTRL_CH7_LSB +: 2]  <= ch7_q;
                    end
                    OFS_CHANNEL_ENABLE_BITS: o_rdata[NCH-1:0] <= channel_enable_bits_q;
                    OFS_STAT: begin
                        o_rdata[STAT_DONE_BIT]        <= done_q;
                        o_rdata[STAT_BUSY_BIT]        <= (state_q != ST_IDLE);
                        o_rdata[STAT_CH_LSB +: CH_W]  <= cur_q;
                        o_rdata[STAT_VALID_LSB +: NCH] <= valid_q;
                        o_rdata[STAT_OVR_LSB +: NCH]  <= ovr_q;
                    end
                    OFS_CLK: begin
                        o_rdata[CLK_DIV_LSB +: 8] <= div_q;
                        o_rdata[CLK_SEL_LSB +: 2] <= sel_q;
                    end
                    default: o_rdata <= '0;
                endcase
            end
        end
    end

    // core side outputs
    assign o_core_start   = (state_q == ST_START);
    assign o_core_channel = cur_q;
    assign o_core_diff    = diff_q;
    assign o_ch7_src      = ch7_q;
    assign o_irq          = done_q && irq_en_q;

    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_rst_b);

    irq_follow_a: assert property (o_irq == (done_q && irq_en_q))
        else $error("irq does not follow done and enable");
    start_wait_a: assert property (o_core_start |=> state_q == ST_WAIT && !o_core_start)
        else $error("start pulse not followed by wait");
    result_store_a: assert property (store |=> res_q[$past(cur_q)] == $past(i_core_result)
                                     && valid_q[$past(cur_q)])
        else $error("result not stored on completion");
    overrun_set_a: assert property (store && valid_q[cur_q] && !(rd_res && rd_ch == cur_q)
                                    |=> ovr_q[$past(cur_q)])
        else $error("overrun not flagged");
    single_end_a: assert property (state_q == ST_NEXT && mode_q == MODE_SINGLE
                                   |=> !start_q && state_q == ST_IDLE)
        else $error("single mode did not stop");
    done_pass_a: assert property ($rose(done_q) |-> $past(state_q == ST_NEXT && pass_end))
        else $error("done set before pass end");
    lowest_pick_a: assert property (state_q == ST_IDLE && start_q && seq_mask != '0
                                    |=> cur_q == lowest($past(seq_mask)))
        else $error("wrong first channel");
    cont_restart_a: assert property (state_q == ST_NEXT && start_q && pass_end
                                     && mode_q == MODE_CONT && channel_enable_bits_eff != '0 && !wr_ctrl
                                     |=> state_q == ST_START && start_q)
        else $error("continuous scan did not restart");
    trig_start_a: assert property (trig_fire && !(state_q == ST_NEXT) |=> start_q)
        else $error("trigger did not set start");
endmodule : sarseq_top
`default_nettype wire

// ### hw/sarseq_pkg.sv
`default_nettype none
package sarseq_pkg;
    // bus geometry
    localparam int unsigned ADDR_W    = 8;
    localparam int unsigned DATA_W    = 32;
    localparam int unsigned RES_W     = 12;
    localparam int unsigned NCH       = 8;
    localparam int unsigned CH_W      = 3;
    // register byte offsets
    localparam logic [7:0] OFS_RES0   = 8'h00;   // result regs 0x00..0x1C
    localparam logic [7:0] OFS_CTRL   = 8'h20;
    localparam logic [7:0] OFS_CHANNEL_ENABLE_BITS   = 8'h24;
    localparam logic [7:0] OFS_STAT   = 8'h28;
    localparam logic [7:0] OFS_CLK    = 8'h2C;
    // control register fields
    localparam int unsigned CTRL_IE_BIT    = 0;
    localparam int unsigned CTRL_MODE_LSB  = 2;
    localparam int unsigned CTRL_TRIGGER_SOURCE_SELECT_LSB  = 4;
    localparam int unsigned CTRL_TCOND_LSB = 6;
    localparam int unsigned CTRL_EXT_TRIGGER_ENABLE_BIT = 8;
    localparam int unsigned CTRL_DIFF_BIT  = 10;
    localparam int unsigned CTRL_START_BIT = 11;
    localparam int unsigned CTRL_CH7_LSB   = 12;
    // result register fields
    localparam int unsigned RES_OVR_BIT    = 16;
    localparam int unsigned RES_VALID_BIT  = 17;
    // status register fields
    localparam int unsigned STAT_DONE_BIT  = 0;
    localparam int unsigned STAT_BUSY_BIT  = 1;
    localparam int unsigned STAT_CH_LSB    = 4;
    localparam int unsigned STAT_VALID_LSB = 8;
    localparam int unsigned STAT_OVR_LSB   = 16;
    // clock register fields
    localparam int unsigned CLK_DIV_LSB    = 0;
    localparam int unsigned CLK_SEL_LSB    = 8;
    // reset values
    localparam logic [7:0] CHANNEL_ENABLE_BITS_RST        = 8'h00;
    localparam logic [7:0] DIV_RST         = 8'h00;
    localparam logic [1:0] SEL_RST         = 2'h0;
    // trigger filter counts, in clock cycles
    localparam int unsigned RUN_W          = 4;
    localparam logic [3:0] LEVEL_HOLD_CYC  = 4'h8;
    localparam logic [3:0] EDGE_HOLD_CYC   = 4'h4;
    // trigger source and condition codes
    localparam logic [1:0] TRG_PIN         = 2'h0;
    localparam logic [1:0] TRG_PWM         = 2'h3;
    localparam logic [1:0] COND_LOW        = 2'h0;
    localparam logic [1:0] COND_HIGH       = 2'h1;
    localparam logic [1:0] COND_FALL       = 2'h2;
    localparam logic [1:0] COND_RISE       = 2'h3;
    // operating modes
    typedef enum logic [1:0] {
        MODE_SINGLE = 2'h0,
        MODE_RSVD   = 2'h1,
        MODE_SCAN   = 2'h2,
        MODE_CONT   = 2'h3
    } sarseq_mode_e;
    // sequencer states, gray along idle-start-wait-next
    typedef enum logic [1:0] {
        ST_IDLE  = 2'h0,
        ST_START = 2'h1,
        ST_WAIT  = 2'h3,
        ST_NEXT  = 2'h2
    } sarseq_state_e;
endpackage : sarseq_pkg
`default_nettype wire

// ### bench/sarseq_core_model.sv
`timescale 1ns/1ps
`default_nettype none
// analog core stand-in: one conversion per start, prompt or slow
module sarseq_core_model (
    input  wire logic        i_clock,
    input  wire logic        i_start,
    input  wire logic [2:0]  i_channel,
    output logic             o_done,
    output logic [11:0]      o_result
);
    // answer each start after one to five cycles
    initial begin
        int d;
        o_done = 1'b0;
        o_result = 12'hFFF;
        forever begin
            @(posedge i_clock);
            if (i_start === 1'b1) begin
                d = 1 + $urandom_range(4);
                repeat (d) @(posedge i_clock);
                o_done <= 1'b1;
                o_result <= {i_channel, 9'h15A};
                @(posedge i_clock);
                o_done <= 1'b0;
                o_result <= ~o_result;  // stale data never holds
            end
        end
    end
endmodule : sarseq_core_model
`default_nettype wire

// ### bench/test_sarseq_top.sv
`timescale 1ns/1ps
`default_nettype none
module test_sarseq_top;
    import sarseq_pkg::*;
    logic        clk, rst_b, wr, rd, trg, pwm, c_done, start, diff, irq, tick, src_on, sp;
    logic [7:0]  addr;
    logic [31:0] wdata, rdata, v, r;
    logic [3:0]  src;
    logic [2:0]  chan;
    logic [1:0]  ch7;
    logic [11:0] res;
    int          n_mismatch, comparisons, i, n_edge, n_tick;
    logic [2:0]  q[$];  // channels in start order

    sarseq_top sarseq_top_inst (.i_clock(clk), .i_rst_b(rst_b), .i_addr(addr),
        .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_ext_trigger(trg),
        .i_pwm_center(pwm), .i_clk_src(src), .o_conv_tick(tick), .o_core_start(start),
        .o_core_channel(chan), .o_core_diff(diff), .o_ch7_src(ch7),
        .i_core_done(c_done), .i_core_result(res), .o_irq(irq));
    sarseq_core_model sarseq_core_model_inst (.i_clock(clk), .i_start(start),
        .i_channel(chan), .o_done(c_done), .o_result(res));

    // 40 MHz clock
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // source clocks wander at random once enabled; log every core start
    // rising edges of the selected source and divider ticks are counted here
    always @(posedge clk) begin
        src <= src_on ? 4'($urandom) : 4'h0;
        if (start === 1'b1) q.push_back(chan);
        if (src[v[9:8]] === 1'b1 && sp !== 1'b1) n_edge++;
        if (tick === 1'b1) n_tick++;
        sp <= src[v[9:8]];
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg
    task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 d = rdata;  // data stands only this cycle
    endtask : rd_reg
    // poll a status bit, bounded
    task automatic wait_stat(input int b, input logic val);
        logic [31:0] s;
        int n;
        for (n = 0; n < 3000; n++) begin
            rd_reg(OFS_STAT, s);
            if (s[b] === val) break;
        end
        if (n == 3000) check(32'h0, 32'h1);
    endtask : wait_stat
    // one pass in single or scan mode, then check order, flags and results
    task automatic run(input logic [1:0] mode, input logic [7:0] m, input logic dif,
                       input logic by_pwm, input logic rb, input logic ov);
        logic [7:0]  e;
        logic [1:0]  c7;
        logic [31:0] s;
        int c;
        e = dif ? (m & 8'h55) : m;
        if (mode != 2'h2) e = e & (~e + 8'h01);  // only the lowest enabled
        c7 = 2'($urandom);
        q.delete();
        wr_reg(OFS_CHANNEL_ENABLE_BITS, {24'h0, m});
        wr_reg(OFS_CTRL, {18'h0, c7, !by_pwm, dif, 1'b0, by_pwm, 2'h0, {2{by_pwm}}, mode, 2'h1});
        #1 check(ch7, c7);
        check(diff, dif);
        if (by_pwm) begin
            @(posedge clk);
            pwm <= 1'b1;
            @(posedge clk);
            pwm <= 1'b0;
        end
        repeat (3) @(posedge clk);
        wait_stat(1, 1'b0);
        check(q.size(), $countones(e));
        for (c = 0; c < 8; c++) if (e[c]) check(q.pop_front(), c);
        rd_reg(OFS_STAT, s);
        check(s[1:0], {1'b0, e != 8'h0});
        check(irq, e != 8'h0);
        rd_reg(OFS_CTRL, s);
        check(s[11], 1'b0);
        wr_reg(OFS_STAT, 32'h1);
        #1 check(irq, 1'b0);
        for (c = 0; c < 8 && rb; c++) begin
            rd_reg(8'(4 * c), s);
            if (e[c]) check(s[17:0], {1'b1, ov, 4'h0, 3'(c), 9'h15A});
            else check(s[17:16], 2'h0);
        end
        $display("test done mode=%0d mask=%h", mode, m);
    endtask : run
    task automatic report_and_stop;
        $display("comparisons=%0d n_mismatch=%0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : report_and_stop

    // main sequence
    initial begin
        {rst_b, wr, rd, trg, pwm, addr, wdata, src_on} = '0;
        n_mismatch = 0;
        comparisons = 0;
        v = $urandom(32'h55C4);
        repeat (10) @(posedge clk);
        rst_b <= 1'b1;
        v = $urandom;
        wr_reg(OFS_CLK, v);
        rd_reg(OFS_CLK, r);
        check(r[9:0], v[9:0]);
        src_on <= 1'b1;
        run(2'h0, 8'h0A, 1'b0, 1'b0, 1'b1, 1'b0);
        run(2'h0, 8'h01, 1'b0, 1'b0, 1'b0, 1'b0);
        run(2'h1, 8'h81, 1'b0, 1'b0, 1'b1, 1'b1);
        run(2'h2, 8'hFF, 1'b0, 1'b0, 1'b1, 1'b0);
        run(2'h2, 8'h8D, 1'b0, 1'b1, 1'b1, 1'b0);
        run(2'h2, 8'h2E, 1'b1, 1'b0, 1'b1, 1'b0);
        run(2'h2, 8'hAA, 1'b1, 1'b0, 1'b1, 1'b0);
        for (i = 0; i < 12; i++)
            run(2'($urandom_range(2)), 8'($urandom), 1'($urandom), 1'($urandom), 1'b1, 1'b0);
        // pin trigger: level high 7 ignored, 8 starts; rising 3 ignored, 4 starts
        q.delete();
        wr_reg(OFS_CHANNEL_ENABLE_BITS, 32'h8D);
        for (i = 0; i < 4; i++) begin
            if (i % 2 == 0) wr_reg(OFS_CTRL, (i == 0) ? 32'h149 : 32'h1C9);
            @(posedge clk);
            trg <= 1'b1;
            repeat ((i < 2 ? 7 : 3) + i % 2) @(posedge clk);
            trg <= 1'b0;
            repeat (20) @(posedge clk);
            wait_stat(1, 1'b0);
            check(q.size(), 4 * (i % 2));
            q.delete();
        end
        wr_reg(OFS_STAT, 32'h1);
        $display("test done pin trigger");
        // continuous scan, then stop by clearing start
        q.delete();
        wr_reg(OFS_CHANNEL_ENABLE_BITS, 32'h8D);
        wr_reg(OFS_CTRL, 32'h80D);
        wait_stat(0, 1'b1);
        wr_reg(OFS_CTRL, 32'h00D);
        wait_stat(1, 1'b0);
        i = q.size();
        check(i >= 5, 1'b1);
        foreach (q[k]) if (k < 5) check(q[k], {3'h0, 3'h2, 3'h3, 3'h7, 3'h0} >> (3 * (4 - k)) & 7);
        repeat (40) @(posedge clk);
        check(q.size(), i);
        $display("test done continuous");
        // freeze the sources, let the last tick drain, then count
        src_on <= 1'b0;
        repeat (5) @(posedge clk);
        check(n_tick, n_edge / (v[7:0] + 1));
        $display("test done divider");
        report_and_stop();
    end
    // watchdog
    initial begin
        #2_000_000;
        n_mismatch++;
        report_and_stop();
    end
endmodule : test_sarseq_top
`default_nettype wire
